// ===== pkg/tcu8_consts.svh
// tcu8_consts.svh: offsets-free constants of the 8-bit compare timer.
// assumes: included by bare name from design files; definitions only.
`ifndef TCU8_CONSTS_SVH
`define TCU8_CONSTS_SVH

// ==========================================================
// count extremes
`define TCU8_BOTTOM        8'h00
`define TCU8_MAX           8'hff
// ==========================================================
// mode encodings of the 2-bit waveform mode field
`define TCU8_WGM_NORMAL    2'h0
`define TCU8_WGM_PHASE     2'h1
`define TCU8_WGM_CLEAR     2'h2
`define TCU8_WGM_FAST      2'h3
// ==========================================================
// output action encodings
`define TCU8_COM_NONE      2'h0
`define TCU8_COM_TOGGLE    2'h1
`define TCU8_COM_CLEAR     2'h2
`define TCU8_COM_SET       2'h3
// ==========================================================
// reset values and prescaler width
`define TCU8_COUNT_RST     8'h00
`define TCU8_CMP_RST       8'h00
`define TCU8_PRE_WIDTH     10

`endif

// ===== pkg/tcu8_pkg.sv
// tcu8_pkg: types shared by the compare timer files.
// assumes: compiled before any design module.
package tcu8_pkg;
    // counting direction of the dual-slope mode
    typedef enum logic {
        TCU8_UP,
        TCU8_DOWN
    } tcu8_dir_e;
    typedef logic [7:0] tcu8_byte_t;
endpackage

// ===== hw/tcu8_clk_sel.sv
// tcu8_clk_sel: timer clock enable generator with 10-bit prescaler.
// assumes: i_xtal_tick is a one-cycle pulse already in the i_ref_clk domain.
`timescale 1ns/1ps
`include "tcu8_consts.svh"
module tcu8_clk_sel
    import tcu8_pkg::*;
#(
    parameter int PRE_W = `TCU8_PRE_WIDTH
) (
    // clock and reset
    input  wire logic       i_ref_clk,
    input  wire logic       i_sys_rst,
    // source selection
    input  wire logic       i_async_clock_select,
    input  wire logic       i_xtal_tick,
    input  wire logic [2:0] i_clock_select,
    // timer clock enable
    output logic            o_timer_tick
);
    // ==========================================================
    // source and prescaler
    logic             src_tick;
    logic [PRE_W-1:0] pre_q;
    logic [PRE_W-1:0] pre_inc;
    logic [PRE_W-1:0] wrap;
    logic             sel_tick;

    // internal clock ticks every cycle, crystal only on its rising edges
    assign src_tick = i_async_clock_select ? i_xtal_tick : 1'b1; // RULE4 RULE5
    assign pre_inc  = pre_q + {{(PRE_W-1){1'b0}}, 1'b1};
    // a tap fires when the low bits all roll over on a source tick
    assign wrap     = ~pre_q;

    // divisions 1, 8, 32, 64, 128, 256, 1024
    always_comb begin
        case (i_clock_select)
            3'h1:    sel_tick = src_tick;
            3'h2:    sel_tick = src_tick & (pre_q[2:0] == 3'h7);
            3'h3:    sel_tick = src_tick & (pre_q[4:0] == 5'h1f);
            3'h4:    sel_tick = src_tick & (pre_q[5:0] == 6'h3f);
            3'h5:    sel_tick = src_tick & (pre_q[6:0] == 7'h7f);
            3'h6:    sel_tick = src_tick & (pre_q[7:0] == 8'hff);
            3'h7:    sel_tick = src_tick & (wrap == '0);
            default: sel_tick = 1'b0; // RULE6
        endcase
    end

    // prescaler runs freely on source ticks; RULE28
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pre_q <= '0;
        end else if (src_tick) begin
            pre_q <= pre_inc;
        end
    end

    // registered so the top sees a clean one-cycle enable
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_timer_tick <= 1'b0;
        end else begin
            o_timer_tick <= sel_tick;
        end
    end
endmodule

// ===== hw/tcu8_timer.sv
// tcu8_timer: 8-bit timer/counter with one compare channel.
// assumes: software strobes are one-cycle pulses on i_ref_clk; osc_pin_in is a raw pin.
// Functional notes
// RULE1: counter and compare value are eight bits
// RULE2: floor at 0x00, ceiling at 0xFF flagged
// RULE3: limit is 0xFF or compare value per mode
// RULE4: timer clock defaults to internal clock
// RULE5: async select takes clock from crystal pins
// RULE6: clock select zero stops the counter
// RULE7: each timer tick clears, increments or decrements
// RULE8: counter readable and writable without timer clock
// RULE9: software counter write beats clear or count
// RULE10: waveform mode sets sequence and overflow flag
// RULE11: compare flag set one tick after equality
// RULE12: compare flag interrupts; clears on ack or one
// RULE13: flags and masks shown through shared registers
// RULE14: compare buffered in pulse modes only
// RULE15: buffer loads at top or bottom only
// RULE16: writes reach buffer or active register
// RULE17: force strobe acts on output only
// RULE18: counter write blocks next tick's match
// RULE19: output formed from match, ceiling, floor
// RULE20: output state holds across mode changes
// RULE21: output action changes apply at once
// RULE22: software avoids counter writes equal to compare
// RULE23: mode zero counts up, overflow at wrap
// RULE24: mode two clears counter on match
// RULE25: mode three single slope, set/clear output
// RULE26: output action zero leaves output unchanged
// RULE27: mode one counts up then down
// RULE28: prescaler divides source for nonzero selects
`timescale 1ns/1ps
`include "tcu8_consts.svh"
module tcu8_timer
    import tcu8_pkg::*;
(
    // clock and reset
    input  wire logic       i_ref_clk,
    input  wire logic       i_sys_rst,
    // crystal oscillator pins
    input  wire logic       i_osc_pin_in,
    output logic            o_osc_pin_out,
    // control fields
    input  wire logic       i_async_clock_select,
    input  wire logic [2:0] i_clock_select,
    input  wire logic [1:0] i_waveform_mode,
    input  wire logic [1:0] i_output_action,
    input  wire logic       i_force_compare,
    input  wire logic       i_compare_irq_enable,
    input  wire logic       i_overflow_irq_enable,
    // counter access
    input  wire logic       i_count_wr,
    input  wire logic [7:0] i_count_wdata,
    output logic [7:0]      o_count_value,
    // compare access
    input  wire logic       i_compare_wr,
    input  wire logic [7:0] i_compare_wdata,
    output logic [7:0]      o_compare_value,
    // flags: write-one-to-clear and interrupt acknowledge
    input  wire logic       i_flag_clr_overflow,
    input  wire logic       i_flag_clr_compare,
    input  wire logic       i_irq_ack_overflow,
    input  wire logic       i_irq_ack_compare,
    output logic            o_overflow_flag,
    output logic            o_compare_flag,
    output logic            o_overflow_irq,
    output logic            o_compare_irq,
    // waveform output
    output logic            o_compare_output
);
    // ==========================================================
    // state
    tcu8_byte_t cnt_q;
    tcu8_byte_t cnt_d;
    tcu8_byte_t ocr_q;
    tcu8_byte_t ocr_buf_q;
    tcu8_dir_e  dir_q;
    tcu8_dir_e  dir_d;
    logic       oc_q;
    logic       oc_d;
    logic       ovf_q;
    logic       cmpf_q;
    logic       block_q;
    logic       ovf_irq_q;
    logic       cmp_irq_q;
    logic [2:0] xs_q;
    logic       xlvl_q;
    logic       xtal_tick;
    logic       tick;

    // ==========================================================
    // crystal pin: three flops, rising edge counts when second and third agree high
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            xs_q <= 3'h0;
        end else begin
            xs_q <= {xs_q[1:0], i_osc_pin_in};
        end
    end
    // accepted level moves only once the second and third flops agree
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            xlvl_q <= 1'b0;
        end else if (xs_q[1] == xs_q[2]) begin
            xlvl_q <= xs_q[2];
        end
    end
    // a rise of the accepted level is one source tick; RULE5
    assign xtal_tick = xs_q[1] & xs_q[2] & ~xlvl_q;

    // the oscillator's inverting output leg
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_osc_pin_out <= 1'b1;
        end else begin
            o_osc_pin_out <= ~xs_q[2];
        end
    end

    // ==========================================================
    // timer clock enable
    tcu8_clk_sel u_clk_sel (
        .i_ref_clk            (i_ref_clk),
        .i_sys_rst            (i_sys_rst),
        .i_async_clock_select (i_async_clock_select),
        .i_xtal_tick          (xtal_tick),
        .i_clock_select       (i_clock_select),
        .o_timer_tick         (tick)
    );

    // ==========================================================
    // decode of mode, extremes and match
    logic is_pwm;
    logic at_bottom;
    logic at_max;
    logic at_top;
    logic match;
    logic match_ev;
    logic dual;
    assign is_pwm    = i_waveform_mode[0]; // modes 1 and 3
    assign dual      = (i_waveform_mode == `TCU8_WGM_PHASE);
    assign at_bottom = (cnt_q == `TCU8_BOTTOM); // RULE2
    assign at_max    = (cnt_q == `TCU8_MAX); // RULE2
    // limit is the compare value only in clear-on-match mode
    assign at_top    = (i_waveform_mode == `TCU8_WGM_CLEAR) ? (cnt_q == ocr_q) : at_max; // RULE3
    assign match     = (cnt_q == ocr_q); // RULE1
    // a counter write blocks matches during the next timer tick
    assign match_ev  = tick & match & ~block_q; // RULE18

    // ==========================================================
    // counting sequence per mode
    always_comb begin
        cnt_d = cnt_q;
        dir_d = dir_q;
        if (tick) begin
            case (i_waveform_mode)
                `TCU8_WGM_NORMAL: cnt_d = cnt_q + 8'h01; // RULE23
                `TCU8_WGM_CLEAR:  cnt_d = at_top ? `TCU8_BOTTOM : cnt_q + 8'h01; // RULE24
                `TCU8_WGM_FAST:   cnt_d = at_max ? `TCU8_BOTTOM : cnt_q + 8'h01; // RULE25
                `TCU8_WGM_PHASE: begin
                    // turn around at the extremes; RULE27
                    if (dir_q == TCU8_UP) begin
                        if (at_max) begin
                            dir_d = TCU8_DOWN;
                            cnt_d = cnt_q - 8'h01;
                        end else begin
                            cnt_d = cnt_q + 8'h01;
                        end
                    end else begin
                        if (at_bottom) begin
                            dir_d = TCU8_UP;
                            cnt_d = cnt_q + 8'h01;
                        end else begin
                            cnt_d = cnt_q - 8'h01;
                        end
                    end
                end
                default: cnt_d = cnt_q;
            endcase // RULE7 RULE10
        end
        if (!dual) begin
            dir_d = TCU8_UP;
        end
        if (i_count_wr) begin
            cnt_d = i_count_wdata; // RULE8 RULE9
        end
    end

    // counter and direction
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cnt_q <= `TCU8_COUNT_RST;
            dir_q <= TCU8_UP;
        end else begin
            cnt_q <= cnt_d;
            dir_q <= dir_d;
        end
    end

    // match blocking window lasts until the next timer tick
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            block_q <= 1'b0;
        end else if (i_count_wr) begin
            block_q <= 1'b1; // RULE18
        end else if (tick) begin
            block_q <= 1'b0;
        end
    end

    // ==========================================================
    // compare value, buffered only in pulse-width modes
    logic ocr_update;
    assign ocr_update = is_pwm & tick & (dual ? at_max : at_bottom); // RULE15

    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ocr_buf_q <= `TCU8_CMP_RST;
        end else if (i_compare_wr) begin
            ocr_buf_q <= i_compare_wdata; // RULE16
        end
    end

    // direct write wins when unbuffered, else load at the cycle boundary
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ocr_q <= `TCU8_CMP_RST;
        end else if (!is_pwm && i_compare_wr) begin
            ocr_q <= i_compare_wdata; // RULE14 RULE16
        end else if (!is_pwm) begin
            ocr_q <= ocr_buf_q & ocr_q | ocr_q & ~ocr_buf_q;
        end else if (ocr_update) begin
            ocr_q <= ocr_buf_q; // RULE14
        end
    end

    // ==========================================================
    // waveform generator; action field read live, no buffering
    logic force_ev;
    logic act;
    assign force_ev = i_force_compare & ~is_pwm; // RULE17

    always_comb begin
        oc_d = oc_q; // RULE20
        act  = match_ev | force_ev;
        case (i_waveform_mode)
            `TCU8_WGM_FAST: begin
                // non-inverting clears on match, sets at floor
                if (i_output_action[1]) begin
                    if (match_ev) begin
                        oc_d = i_output_action[0]; // RULE25
                    end else if (tick && at_max) begin
                        oc_d = ~i_output_action[0]; // RULE19
                    end
                end
            end
            `TCU8_WGM_PHASE: begin
                // clear on up-match, set on down-match when non-inverting
                if (i_output_action[1] && match_ev) begin
                    oc_d = (dir_q == TCU8_UP) ? i_output_action[0] : ~i_output_action[0];
                end // RULE27
            end
            default: begin
                if (act) begin
                    case (i_output_action)
                        `TCU8_COM_TOGGLE: oc_d = ~oc_q;
                        `TCU8_COM_CLEAR:  oc_d = 1'b0;
                        `TCU8_COM_SET:    oc_d = 1'b1;
                        default:          oc_d = oc_q; // RULE26
                    endcase // RULE19 RULE21
                end
            end
        endcase
    end

    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            oc_q <= 1'b0;
        end else begin
            oc_q <= oc_d;
        end
    end

    // ==========================================================
    // flags: set beats clear in the same cycle
    logic ovf_set;
    logic ovf_clr;
    logic cmp_set;
    logic cmp_clr;
    // normal and clear modes overflow when counting from max to zero
    assign ovf_set = tick & (dual ? at_bottom & (dir_q == TCU8_DOWN) : at_max); // RULE10 RULE23
    assign ovf_clr = i_flag_clr_overflow | i_irq_ack_overflow;
    // equality seen in a tick cycle is registered at the clock edge ending that cycle; RULE11
    assign cmp_set = match_ev;
    assign cmp_clr = i_flag_clr_compare | i_irq_ack_compare; // RULE12

    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ovf_q  <= 1'b0;
            cmpf_q <= 1'b0;
        end else begin
            ovf_q  <= ovf_set | (ovf_q & ~ovf_clr);
            cmpf_q <= cmp_set | (cmpf_q & ~cmp_clr); // RULE11 RULE12
        end
    end

    // masked requests, registered for clean outputs; RULE13
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ovf_irq_q <= 1'b0;
            cmp_irq_q <= 1'b0;
        end else begin
            ovf_irq_q <= ovf_set | (ovf_q & ~ovf_clr) ? i_overflow_irq_enable : 1'b0;
            cmp_irq_q <= cmp_set | (cmpf_q & ~cmp_clr) ? i_compare_irq_enable : 1'b0; // RULE12
        end
    end

    // ==========================================================
    // outputs straight from flops, compare value through a mode-selected mux
    assign o_count_value    = cnt_q;
    assign o_compare_value  = is_pwm ? ocr_buf_q : ocr_q; // RULE16
    assign o_overflow_flag  = ovf_q;
    assign o_compare_flag   = cmpf_q;
    assign o_overflow_irq   = ovf_irq_q;
    assign o_compare_irq    = cmp_irq_q;
    assign o_compare_output = oc_q;
endmodule

// ===== verification/tcu8_timer_sva.sv
// tcu8_timer_sva: port assertions for the 8-bit compare timer.
// assumes: bound into tcu8_timer; strobes are one-cycle pulses.
`timescale 1ns/1ps
module tcu8_timer_sva (
    // clock and reset
    input wire logic       i_ref_clk,
    input wire logic       i_sys_rst,
    // crystal pins
    input wire logic       i_osc_pin_in,
    input wire logic       o_osc_pin_out,
    // controls and strobes
    input wire logic [2:0] i_clock_select,
    input wire logic [1:0] i_waveform_mode,
    input wire logic [1:0] i_output_action,
    input wire logic       i_count_wr,
    input wire logic [7:0] i_count_wdata,
    input wire logic       i_flag_clr_compare,
    input wire logic       i_irq_ack_compare,
    input wire logic       i_compare_irq_enable,
    // observed outputs
    input wire logic [7:0] o_count_value,
    input wire logic [7:0] o_compare_value,
    input wire logic       o_overflow_flag,
    input wire logic       o_compare_flag,
    input wire logic       o_compare_irq,
    input wire logic       o_compare_output
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);
    // in non-pwm modes compare_value shows the active register, so equality is real
    wire logic non_pwm = !i_waveform_mode[0];
    // ==========
    // sequences
    sequence s_step;
        non_pwm && !i_count_wr && (i_waveform_mode == 2'h0 || o_count_value != o_compare_value)
            ##1 $changed(o_count_value);
    endsequence
    sequence s_ctc_hit;
        i_waveform_mode == 2'h2 && !i_count_wr && !$past(i_count_wr)
            && o_count_value == o_compare_value ##1 $changed(o_count_value);
    endsequence
    sequence s_quiet;
        (i_output_action == 2'h0 && non_pwm)[*2];
    endsequence
    // ==========
    // assertions
    AST_CNT_WR: assert property (i_count_wr |=> o_count_value == $past(i_count_wdata))
        else $error("count write not taken");
    AST_STOP: assert property (i_clock_select == 3'h0 && $past(i_clock_select) == 3'h0
        && !i_count_wr |=> $stable(o_count_value))
        else $error("stopped counter moved");
    AST_UP: assert property (s_step |-> o_count_value == $past(o_count_value) + 8'h01)
        else $error("count step not plus one");
    AST_CTC: assert property (s_ctc_hit |-> o_count_value == 8'h00)
        else $error("match did not clear counter");
    AST_OVF: assert property ($rose(o_overflow_flag) && i_waveform_mode == 2'h0
        && !$past(i_count_wr) |-> o_count_value == 8'h00)
        else $error("overflow flag away from zero");
    AST_CMP: assert property ($rose(o_compare_flag) && non_pwm
        |-> $past(o_count_value) == $past(o_compare_value))
        else $error("compare flag without equality");
    AST_CLR: assert property ((i_flag_clr_compare || i_irq_ack_compare) && non_pwm
        && o_count_value != o_compare_value |=> !o_compare_flag)
        else $error("compare flag not cleared");
    // the request register sees the next flag value but the enable of the cycle before
    AST_IRQ: assert property (o_compare_irq
        == (o_compare_flag && $past(i_compare_irq_enable)))
        else $error("compare irq not flag and enable");
    // drive leg is the inverted pin after three sync flops and one output flop
    AST_OSC: assert property (!$past(i_sys_rst, 4)
        |-> o_osc_pin_out == !$past(i_osc_pin_in, 4))
        else $error("crystal drive leg not inverted pin");
    AST_ACT_NONE: assert property (s_quiet |=> $stable(o_compare_output))
        else $error("output moved with no action");
endmodule

bind tcu8_timer tcu8_timer_sva i_sva (.*);

// ===== verification/tcu8_xtal_model.sv
// tcu8_xtal_model: watch crystal oscillating on the timer's crystal pins.
// assumes: the drive pin is only loaded, never needed to start oscillation.
`timescale 1ns/1ps
module tcu8_xtal_model #(
    parameter int HALF_NS = 488
) (
    // supply and pins
    input  wire logic i_en,
    input  wire logic i_osc_pin_out,
    output logic      o_osc_pin_in
);
    // even half period drifts against the clock but never lands on its odd-ns rising edge
    initial o_osc_pin_in = 1'b0;
    always #(HALF_NS) o_osc_pin_in = i_en ? ~o_osc_pin_in : 1'b0;
endmodule

// ===== verification/tcu8_timer_tb_top.sv
// tcu8_timer_tb_top: self-checking bench for the 8-bit compare timer.
// assumes: package, design, checker and crystal model compiled first.
`timescale 1ns/1ps
module tcu8_timer_tb_top;
    import tcu8_pkg::*;
    // ==========
    // stimulus and observation
    logic        i_ref_clk = 1'b0;
    logic        i_sys_rst = 1'b1;
    logic        async_sel = 1'b0;
    logic [2:0]  clk_sel   = 3'h0;
    logic [1:0]  mode      = 2'h0;
    logic [1:0]  action    = 2'h0;
    logic        cmp_ie    = 1'b0;
    logic        ovf_ie    = 1'b0;
    logic        cnt_wr    = 1'b0;
    logic        cmp_wr    = 1'b0;
    logic        frc       = 1'b0;
    logic        clr_cmp   = 1'b0;
    logic        ack_cmp   = 1'b0;
    logic        clr_ovf   = 1'b0;
    logic        ack_ovf   = 1'b0;
    logic [7:0]  wdata     = 8'h00;
    logic [7:0]  cnt_val, cmp_val;
    logic        ovf_flag, cmp_flag, ovf_irq, cmp_irq, cmp_out, osc_in, osc_out;
    logic        rd_req    = 1'b0;
    logic [10:0] note;
    logic [10:0] exp_q[$];
    logic [1:0]  acts[5]   = '{2'h1, 2'h3, 2'h2, 2'h1, 2'h0};
    logic        outs[5]   = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
    int          error_cnt = 0;
    int          samples_checked = 0;
    int          seed      = 32'h1abd;
    int          cycles    = 0;
    int          r;
    localparam logic [6:0] W_CNT = 7'h40, W_CMP = 7'h20, FRC = 7'h10, CLR_C = 7'h08;
    localparam logic [6:0] ACK_C = 7'h04, CLR_O = 7'h02, ACK_O = 7'h01;

    always #25 i_ref_clk = ~i_ref_clk;

    tcu8_timer i_dut (
        .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
        .i_osc_pin_in(osc_in), .o_osc_pin_out(osc_out),
        .i_async_clock_select(async_sel), .i_clock_select(clk_sel),
        .i_waveform_mode(mode), .i_output_action(action), .i_force_compare(frc),
        .i_compare_irq_enable(cmp_ie), .i_overflow_irq_enable(ovf_ie),
        .i_count_wr(cnt_wr), .i_count_wdata(wdata), .o_count_value(cnt_val),
        .i_compare_wr(cmp_wr), .i_compare_wdata(wdata), .o_compare_value(cmp_val),
        .i_flag_clr_overflow(clr_ovf), .i_flag_clr_compare(clr_cmp),
        .i_irq_ack_overflow(ack_ovf), .i_irq_ack_compare(ack_cmp),
        .o_overflow_flag(ovf_flag), .o_compare_flag(cmp_flag),
        .o_overflow_irq(ovf_irq), .o_compare_irq(cmp_irq), .o_compare_output(cmp_out));

    tcu8_xtal_model i_xtal (.i_en(1'b1), .i_osc_pin_out(osc_out), .o_osc_pin_in(osc_in));

    // ==========
    // driver tasks: strobes are one cycle wide, then one idle edge
    task automatic strobe(input logic [6:0] m, input logic [7:0] d);
        wdata <= d;
        {cnt_wr, cmp_wr, frc, clr_cmp, ack_cmp, clr_ovf, ack_ovf} <= m;
        @(posedge i_ref_clk);
        {cnt_wr, cmp_wr, frc, clr_cmp, ack_cmp, clr_ovf, ack_ovf} <= 7'h00;
        @(posedge i_ref_clk);
    endtask
    task automatic expect_val(input logic [2:0] kind, input logic [7:0] val);
        exp_q.push_back({kind, val});
        rd_req <= 1'b1;
        @(posedge i_ref_clk);
        rd_req <= 1'b0;
        @(posedge i_ref_clk);
    endtask
    // bounded wait so a dead flag ends in a mismatch, not a hang
    task automatic wait_flag(input logic want_cmp);
        int n;
        n = 0;
        while ((want_cmp ? cmp_flag : ovf_flag) !== 1'b1 && n < 600) begin
            @(posedge i_ref_clk);
            n++;
        end
    endtask

    // ==========
    // compare tasks and monitor
    task automatic cmp_byte(input string nm, input logic [7:0] e, input logic [7:0] s);
        samples_checked++;
        if (s !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic cmp_bit(input string nm, input logic e, input logic s);
        samples_checked++;
        if (s !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %b seen %b", nm, e, s);
        end
    endtask
    always @(posedge i_ref_clk) begin
        if (rd_req && exp_q.size() > 0) begin
            note = exp_q.pop_front();
            case (note[10:8])
                3'h0: cmp_byte("count_value", note[7:0], cnt_val);
                3'h1: cmp_byte("compare_value", note[7:0], cmp_val);
                3'h2: cmp_bit("compare_flag", note[0], cmp_flag);
                3'h3: cmp_bit("overflow_flag", note[0], ovf_flag);
                3'h4: cmp_bit("compare_output", note[0], cmp_out);
                3'h5: cmp_bit("compare_irq", note[0], cmp_irq);
                3'h6: cmp_bit("slow_count", note[0], cnt_val != 8'h00 && cnt_val < 8'h10);
                3'h7: cmp_bit("overflow_irq", note[0], ovf_irq);
                default: cmp_bit("note_kind", 1'b0, 1'b1);
            endcase
        end
    end

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // hang guard: the whole sequence needs well under 3000 cycles
    always @(posedge i_ref_clk) begin
        cycles++;
        if (cycles == 6000) begin
            error_cnt++;
            print_verdict();
        end
    end

    // ==========
    // main sequence
    initial begin
        repeat (20) @(posedge i_ref_clk);
        i_sys_rst <= 1'b0;
        @(posedge i_ref_clk);
        expect_val(3'h0, 8'h00);
        expect_val(3'h3, 8'h00);
        // stopped counter still takes writes; direct compare writes read back
        r = $random(seed);
        strobe(W_CNT, r[7:0]);
        repeat (5) @(posedge i_ref_clk);
        expect_val(3'h0, r[7:0]);
        repeat (3) begin
            r = $random(seed);
            strobe(W_CMP, r[7:0]);
            expect_val(3'h1, r[7:0]);
        end
        // forced matches walk every output action while stopped
        foreach (acts[i]) begin
            action <= acts[i];
            strobe(FRC, 8'h00);
            expect_val(3'h4, {7'h00, outs[i]});
        end
        expect_val(3'h2, 8'h00);
        mode <= 2'h3;
        action <= 2'h1;
        strobe(FRC, 8'h00);
        expect_val(3'h4, 8'h01);
        strobe(W_CMP, 8'h5a);
        expect_val(3'h1, 8'h5a);
        // normal mode run: overflow, compare match, interrupt and acknowledge
        mode <= 2'h0;
        action <= 2'h0;
        strobe(W_CMP, 8'h40);
        strobe(W_CNT, 8'hf0);
        strobe(CLR_C | CLR_O, 8'h00);
        {cmp_ie, ovf_ie, clk_sel} <= {2'b11, 3'h1};
        wait_flag(1'b0);
        expect_val(3'h3, 8'h01);
        expect_val(3'h7, 8'h01);
        strobe(ACK_O, 8'h00);
        expect_val(3'h3, 8'h00);
        wait_flag(1'b1);
        expect_val(3'h2, 8'h01);
        expect_val(3'h5, 8'h01);
        strobe(ACK_C, 8'h00);
        expect_val(3'h2, 8'h00);
        // writing the compare value into the running counter hides that match
        strobe(W_CNT, 8'h40);
        repeat (20) @(posedge i_ref_clk);
        expect_val(3'h2, 8'h00);
        // clear-on-match mode
        clk_sel <= 3'h0;
        mode <= 2'h2;
        strobe(W_CMP, 8'h10);
        strobe(W_CNT, 8'h00);
        strobe(CLR_C, 8'h00);
        clk_sel <= 3'h1;
        repeat (60) @(posedge i_ref_clk);
        expect_val(3'h2, 8'h01);
        // phase-correct run: fc up to ff, then back down to fb
        clk_sel <= 3'h0;
        mode <= 2'h1;
        strobe(W_CNT, 8'hfc);
        clk_sel <= 3'h1;
        repeat (8) @(posedge i_ref_clk);
        expect_val(3'h0, 8'hfb);
        // crystal source is far slower than the reference clock
        clk_sel <= 3'h0;
        mode <= 2'h0;
        strobe(W_CNT, 8'h00);
        {async_sel, clk_sel} <= {1'b1, 3'h1};
        repeat (120) @(posedge i_ref_clk);
        expect_val(3'h6, 8'h01);
        print_verdict();
    end
endmodule
